//--- logic/assc_pkg.sv
// Purpose: Shared constants and types for the seek, sense and set-features block
// Assumes: Classic Wishbone register access, 8-bit registers (11-bit environment word) in 32-bit words
// Notes: Offsets are byte addresses
package assc_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADR_FEATURE = 8'h00;
    localparam logic [7:0] ADR_SECCNT = 8'h04;
    localparam logic [7:0] ADR_LBA_LOW = 8'h08;
    localparam logic [7:0] ADR_LBA_MID = 8'h0c;
    localparam logic [7:0] ADR_LBA_HIGH = 8'h10;
    localparam logic [7:0] ADR_DEVICE = 8'h14;
    localparam logic [7:0] ADR_COMMAND = 8'h18;
    localparam logic [7:0] ADR_ERROR = 8'h1c;
    localparam logic [7:0] ADR_STATUS = 8'h20;
    localparam logic [7:0] ADR_FEAT_STATE = 8'h24;
    localparam logic [7:0] ADR_XFER_MODE = 8'h28;
    localparam logic [7:0] ADR_ENV = 8'h2c;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int ERR_ABT_BIT = 2;
    localparam int ERR_IDN_BIT = 4;
    localparam int ST_ERR_BIT = 0;
    localparam int ST_DSC_BIT = 4;
    localparam int ST_RDY_BIT = 6;
    localparam int ST_BSY_BIT = 7;
    localparam int DEV_LBA_BIT = 6;
    localparam int LOW_OVERSTRESS_BIT = 0;
    // ----------------------------------------
    // Opcodes and feature codes
    // ----------------------------------------
    localparam logic [3:0] OP_SEEK_NIB = 4'h7;
    localparam logic [7:0] OP_SENSE = 8'hf0;
    localparam logic [7:0] OP_SETFEAT = 8'hef;
    localparam logic [7:0] SENSE_FEAT = 8'h01;
    localparam logic [7:0] FC_WC_ON = 8'h02;
    localparam logic [7:0] FC_XFER = 8'h03;
    localparam logic [7:0] FC_APM_ON = 8'h05;
    localparam logic [7:0] FC_AOFS_ON = 8'h09;
    localparam logic [7:0] FC_ECC40 = 8'h44;
    localparam logic [7:0] FC_RLA_OFF = 8'h55;
    localparam logic [7:0] FC_REV_OFF = 8'h66;
    localparam logic [7:0] FC_WC_OFF = 8'h82;
    localparam logic [7:0] FC_APM_OFF = 8'h85;
    localparam logic [7:0] FC_AOFS_OFF = 8'h89;
    localparam logic [7:0] FC_RLA_ON = 8'haa;
    localparam logic [7:0] FC_ECC4 = 8'hbb;
    localparam logic [7:0] FC_REV_ON = 8'hcc;
    localparam logic [4:0] XT_PIO_DEF = 5'h00;
    localparam logic [4:0] XT_PIO_FC = 5'h01;
    localparam logic [4:0] XT_MDMA = 5'h04;
    localparam logic [4:0] XT_UDMA = 5'h08;
    localparam logic [2:0] PIO_MAX = 3'h4;
    localparam logic [2:0] MDMA_MAX = 3'h2;
    localparam logic [2:0] UDMA_MAX = 3'h4;
    // ----------------------------------------
    // Power levels and reset values
    // ----------------------------------------
    localparam logic [1:0] PWR_ACTIVE_IDLE = 2'h0;
    localparam logic [1:0] PWR_LOW_IDLE = 2'h1;
    localparam logic [1:0] PWR_STANDBY = 2'h2;
    localparam logic [7:0] XFER_RST = 8'h00;
    localparam int SEEK_CYCLES_DEF = 16;
    localparam int SENSE_CYCLES_DEF = 8;

    typedef struct packed {
        logic wcache;
        logic rla;
        logic ecc40;
        logic revert;
        logic aofs;
        logic apm_en;
        logic [1:0] pwr_lvl;
    } assc_feat_t;

    localparam assc_feat_t FEAT_RST = '{wcache: 1'b1, rla: 1'b1, ecc40: 1'b0,
        revert: 1'b0, aofs: 1'b0, apm_en: 1'b0, pwr_lvl: 2'h0};

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DONE = 2'b11
    } assc_state_t;
endpackage

//--- logic/assc_cmd.sv
// Purpose: Command interpreter for seek, temperature sense and set features
// Assumes: Single clock, Wishbone classic slave, environment inputs from pins
// Notes: Register reads show the device view; writes set the host view
`timescale 1ns/1ps
// What this block does
// R1 - Opcodes 7xh start a seek to the requested track and head.
// R2 - Seek runs identically whether or not the media is formatted.
// R3 - CHS seek takes cylinder from high/mid and head from device field.
// R4 - LBA seek target is low, mid, high and head bits in order.
// R5 - After an LBA seek the current address returns in the same registers.
// R6 - Sense needs feature 01h; other values abort.
// R7 - Sense executes without spinning up the spindle.
// R8 - Sense returns the temperature code in sector count.
// R9 - Sense sets the overstress flag in the low register when detected.
// R10 - Undefined set-features codes abort.
// R11 - Reset enables cache and look-ahead, 4 ECC bytes, no revert, no offset.
// R12 - 02h enables write cache, 82h disables it.
// R13 - 55h disables look-ahead, AAh enables it.
// R14 - 66h stops reverting to defaults, CCh re-enables it.
// R15 - 09h enters address offset mode, 89h leaves it.
// R16 - 44h selects 40 ECC bytes, BBh selects 4.
// R17 - 03h takes transfer type and mode from sector count.
// R18 - Transfer types decode to PIO, flow PIO, multiword DMA, Ultra DMA.
// R19 - APM level maps to idle, low idle or standby; 00h and FFh abort.
// R20 - 85h limits the deepest saving state to active idle.
// R21 - Spare exhaustion forces cache off; 02h still accepted silently.
// R22 - Host keeps reset and power for 5 s after cached writes.
// R23 - Busy while executing, then ready with error reflecting abort.
module assc_cmd #(
    parameter int SEEK_CYCLES = assc_pkg::SEEK_CYCLES_DEF,
    parameter int SENSE_CYCLES = assc_pkg::SENSE_CYCLES_DEF
) (
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    input wire logic [7:0] I_TEMP_CODE,
    input wire logic I_OVERSTRESS,
    input wire logic I_SPARE_EXHAUSTED,
    input wire logic I_HARD_RESET,
    output logic O_SEEK_REQ,
    output logic [27:0] O_SEEK_TARGET,
    output logic O_SEEK_LBA,
    output logic O_SPINDLE_SPINUP,
    output assc_pkg::assc_feat_t O_FEATURES,
    output logic [7:0] O_XFER_MODE
);
    import assc_pkg::*;

    if (SEEK_CYCLES < 1 || SEEK_CYCLES > 65535 || SENSE_CYCLES < 1 ||
        SENSE_CYCLES > 65535) begin : gen_bad_cycles
        $error("assc_cmd: cycle counts out of range");
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [10:0] env_s1_q;
    logic [10:0] env_s2_q;
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            env_s1_q <= 11'h000;
            env_s2_q <= 11'h000;
        end else begin
            env_s1_q <= {I_HARD_RESET, I_SPARE_EXHAUSTED, I_OVERSTRESS, I_TEMP_CODE};
            env_s2_q <= env_s1_q;
        end
    end
    // Temperature word taken only when two samples agree
    logic [7:0] temp_s3_q;
    logic [7:0] temp_q;
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            temp_s3_q <= 8'h00;
            temp_q <= 8'h00;
        end else begin
            temp_s3_q <= env_s2_q[7:0];
            if (env_s2_q[7:0] == temp_s3_q) begin
                temp_q <= env_s2_q[7:0];
            end
        end
    end
    logic [7:0] temp_s;
    logic over_s;
    logic spare_s;
    logic hrst_s;
    assign temp_s = temp_q;
    assign over_s = env_s2_q[8];
    assign spare_s = env_s2_q[9];
    assign hrst_s = env_s2_q[10];

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic ack_q;
    logic req;
    logic wr_stb;
    assign req = I_WB_CYC && I_WB_STB && !ack_q;
    assign wr_stb = req && I_WB_WE && I_WB_SEL[0];
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end
    assign O_WB_ACK = ack_q;

    logic [7:0] feat_q;
    logic [7:0] scnt_q;
    logic [7:0] low_q;
    logic [7:0] mid_q;
    logic [7:0] high_q;
    logic [7:0] dev_q;
    logic [7:0] cmd_q;
    logic [7:0] err_q;
    logic bsy_q;
    logic rdy_q;
    logic dsc_q;
    assc_state_t state_q;
    logic [15:0] cnt_q;
    assc_feat_t ft_q;
    logic [7:0] xfer_q;
    logic cmd_go;
    assign cmd_go = wr_stb && I_WB_ADR == ADR_COMMAND && state_q == ST_IDLE;

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    logic is_seek;
    logic is_sense;
    logic is_sf;
    logic [27:0] tgt;
    assign is_seek = cmd_q[7:4] == OP_SEEK_NIB; // see R1
    assign is_sense = cmd_q == OP_SENSE;
    assign is_sf = cmd_q == OP_SETFEAT;
    // see R3 see R4
    assign tgt = dev_q[DEV_LBA_BIT] ? {dev_q[3:0], high_q, mid_q, low_q}
                                    : {dev_q[3:0], high_q, mid_q, 8'h00};

    logic xfer_ok;
    always_comb begin
        unique case (scnt_q[7:3]) // see R17 see R18
            XT_PIO_DEF: xfer_ok = scnt_q[2:0] <= 3'h1;
            XT_PIO_FC: xfer_ok = scnt_q[2:0] <= PIO_MAX;
            XT_MDMA: xfer_ok = scnt_q[2:0] <= MDMA_MAX;
            XT_UDMA: xfer_ok = scnt_q[2:0] <= UDMA_MAX;
            default: xfer_ok = 1'b0;
        endcase
    end

    logic sf_abort;
    always_comb begin
        unique case (feat_q) // see R10
            FC_WC_ON, FC_AOFS_ON, FC_ECC40, FC_RLA_OFF, FC_REV_OFF, FC_WC_OFF,
            FC_APM_OFF, FC_AOFS_OFF, FC_RLA_ON, FC_ECC4, FC_REV_ON: sf_abort = 1'b0;
            FC_XFER: sf_abort = !xfer_ok;
            FC_APM_ON: sf_abort = scnt_q == 8'h00 || scnt_q == 8'hff; // see R19
            default: sf_abort = 1'b1;
        endcase
    end

    logic cmd_abort;
    assign cmd_abort = is_sense ? feat_q != SENSE_FEAT : // see R6
                       is_sf ? sf_abort : !is_seek;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_q <= ST_IDLE;
            cnt_q <= 16'h0000;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (cmd_go) begin
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (cnt_q == 16'h0000) begin
                        cnt_q <= is_seek ? 16'(SEEK_CYCLES) : 16'(SENSE_CYCLES);
                        if (cmd_abort || is_sf) begin
                            cnt_q <= 16'h0001;
                        end
                    end else if (cnt_q == 16'h0001) begin
                        state_q <= ST_DONE;
                        cnt_q <= 16'h0000;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                ST_DONE: state_q <= ST_IDLE;
            endcase
        end
    end
    logic fin;
    assign fin = state_q == ST_DONE;

    // see R23
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            bsy_q <= 1'b0;
            rdy_q <= 1'b1;
            dsc_q <= 1'b1;
            err_q <= 8'h00;
        end else if (cmd_go) begin
            bsy_q <= 1'b1;
            rdy_q <= 1'b0;
            err_q <= 8'h00;
        end else if (fin) begin
            bsy_q <= 1'b0;
            rdy_q <= 1'b1;
            dsc_q <= 1'b1;
            err_q[ERR_ABT_BIT] <= cmd_abort;
        end else if (state_q == ST_EXEC && is_seek) begin
            dsc_q <= 1'b0;
        end
    end

    // Seek request; no format state is consulted
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_SEEK_REQ <= 1'b0;
            O_SEEK_TARGET <= 28'h0000000;
            O_SEEK_LBA <= 1'b0;
        end else begin
            O_SEEK_REQ <= state_q == ST_EXEC && cnt_q == 16'h0000 && is_seek; // see R1 see R2
            if (state_q == ST_EXEC && cnt_q == 16'h0000 && is_seek) begin
                O_SEEK_TARGET <= tgt;
                O_SEEK_LBA <= dev_q[DEV_LBA_BIT];
            end
        end
    end

    // ----------------------------------------
    // Command block registers
    // ----------------------------------------
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            feat_q <= 8'h00;
            scnt_q <= 8'h00;
            low_q <= 8'h00;
            mid_q <= 8'h00;
            high_q <= 8'h00;
            dev_q <= 8'h00;
            cmd_q <= 8'h00;
        end else begin
            if (wr_stb && !bsy_q) begin
                unique case (I_WB_ADR)
                    ADR_FEATURE: feat_q <= I_WB_DAT[7:0];
                    ADR_SECCNT: scnt_q <= I_WB_DAT[7:0];
                    ADR_LBA_LOW: low_q <= I_WB_DAT[7:0];
                    ADR_LBA_MID: mid_q <= I_WB_DAT[7:0];
                    ADR_LBA_HIGH: high_q <= I_WB_DAT[7:0];
                    ADR_DEVICE: dev_q <= I_WB_DAT[7:0];
                    ADR_COMMAND: cmd_q <= I_WB_DAT[7:0];
                    default: ;
                endcase
            end
            if (fin && !cmd_abort && is_seek && dev_q[DEV_LBA_BIT]) begin
                // see R5
                low_q <= O_SEEK_TARGET[7:0];
                mid_q <= O_SEEK_TARGET[15:8];
                high_q <= O_SEEK_TARGET[23:16];
                dev_q[3:0] <= O_SEEK_TARGET[27:24];
            end
            if (fin && !cmd_abort && is_sense) begin
                scnt_q <= temp_s; // see R8
                low_q <= 8'h00;
                low_q[LOW_OVERSTRESS_BIT] <= over_s; // see R9
            end
        end
    end

    // ----------------------------------------
    // Feature state
    // ----------------------------------------
    logic sf_apply;
    assign sf_apply = fin && is_sf && !sf_abort;
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ft_q <= FEAT_RST; // see R11
            xfer_q <= XFER_RST;
        end else begin
            if (hrst_s && ft_q.revert) begin
                ft_q <= FEAT_RST;
                xfer_q <= XFER_RST;
            end else if (sf_apply) begin
                unique case (feat_q)
                    FC_WC_ON: ft_q.wcache <= 1'b1; // see R12
                    FC_WC_OFF: ft_q.wcache <= 1'b0; // see R12
                    FC_RLA_OFF: ft_q.rla <= 1'b0; // see R13
                    FC_RLA_ON: ft_q.rla <= 1'b1; // see R13
                    FC_REV_OFF: ft_q.revert <= 1'b0; // see R14
                    FC_REV_ON: ft_q.revert <= 1'b1; // see R14
                    FC_AOFS_ON: ft_q.aofs <= 1'b1; // see R15
                    FC_AOFS_OFF: ft_q.aofs <= 1'b0; // see R15
                    FC_ECC40: ft_q.ecc40 <= 1'b1; // see R16
                    FC_ECC4: ft_q.ecc40 <= 1'b0; // see R16
                    FC_XFER: xfer_q <= scnt_q; // see R17
                    FC_APM_ON: begin
                        ft_q.apm_en <= 1'b1;
                        // see R19
                        ft_q.pwr_lvl <= scnt_q >= 8'hc0 ? PWR_ACTIVE_IDLE :
                                        scnt_q >= 8'h80 ? PWR_LOW_IDLE : PWR_STANDBY;
                    end
                    FC_APM_OFF: begin
                        ft_q.apm_en <= 1'b0;
                        ft_q.pwr_lvl <= PWR_ACTIVE_IDLE; // see R20
                    end
                    default: ;
                endcase
            end
        end
    end

    // see R21
    always_comb begin
        O_FEATURES = ft_q;
        O_FEATURES.wcache = ft_q.wcache && !spare_s;
    end
    assign O_XFER_MODE = xfer_q;
    assign O_SPINDLE_SPINUP = 1'b0; // see R7

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [7:0] status;
    assign status = {bsy_q, rdy_q, 1'b0, dsc_q, 3'b000, err_q[ERR_ABT_BIT]};
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_WB_DAT <= 32'h00000000;
        end else if (req && !I_WB_WE) begin
            unique case (I_WB_ADR)
                ADR_FEATURE: O_WB_DAT <= {24'h000000, feat_q};
                ADR_SECCNT: O_WB_DAT <= {24'h000000, scnt_q};
                ADR_LBA_LOW: O_WB_DAT <= {24'h000000, low_q};
                ADR_LBA_MID: O_WB_DAT <= {24'h000000, mid_q};
                ADR_LBA_HIGH: O_WB_DAT <= {24'h000000, high_q};
                ADR_DEVICE: O_WB_DAT <= {24'h000000, dev_q};
                ADR_COMMAND: O_WB_DAT <= {24'h000000, cmd_q};
                ADR_ERROR: O_WB_DAT <= {24'h000000, err_q};
                ADR_STATUS: O_WB_DAT <= {24'h000000, status};
                ADR_FEAT_STATE: O_WB_DAT <= {24'h000000, O_FEATURES};
                ADR_XFER_MODE: O_WB_DAT <= {24'h000000, xfer_q};
                ADR_ENV: O_WB_DAT <= {21'h00000, env_s2_q};
                default: O_WB_DAT <= 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence go_s;
        cmd_go;
    endsequence
    seek_start_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // see R1
        O_SEEK_REQ |-> is_seek && bsy_q) else $error("seek request without seek");
    busy_set_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // see R23
        go_s |=> bsy_q && !rdy_q) else $error("busy not set on command");
    busy_clear_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // see R23
        fin |=> !bsy_q && rdy_q) else $error("busy not cleared");
    sense_abort_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // see R6
        fin && is_sense && feat_q != SENSE_FEAT |=> err_q[ERR_ABT_BIT])
        else $error("bad sense feature not aborted");
    sf_abort_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // see R10
        fin && is_sf && feat_q == 8'h00 |=> status[ST_ERR_BIT])
        else $error("undefined feature not aborted");
    wc_off_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // see R21
        spare_s |-> !O_FEATURES.wcache) else $error("cache on after spares exhausted");
    wc_on_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // see R12
        sf_apply && feat_q == FC_WC_ON |=> ft_q.wcache) else $error("cache not enabled");
    rla_off_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // see R13
        sf_apply && feat_q == FC_RLA_OFF |=> !ft_q.rla) else $error("look-ahead not off");
    sense_temp_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // see R8
        fin && is_sense && !cmd_abort |=> scnt_q == $past(temp_s))
        else $error("temperature not returned");
    apm_lvl_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // see R19
        sf_apply && feat_q == FC_APM_ON && scnt_q >= 8'hc0 |=>
        ft_q.pwr_lvl == PWR_ACTIVE_IDLE) else $error("wrong power level");
endmodule // assc_cmd

//--- verification/assc_host.sv
// Purpose: Wishbone host model driving the command block
// Assumes: Classic single cycles, one transfer per call
// Notes: Released write data shows the inverse of its last value
`timescale 1ns/1ps
module assc_host (
    input wire logic i_clk,
    output logic o_cyc,
    output logic o_stb,
    output logic o_we,
    output logic [7:0] o_adr,
    output logic [3:0] o_sel,
    output logic [31:0] o_dat,
    input wire logic [31:0] i_dat,
    input wire logic i_ack
);
    initial begin
        o_cyc = 1'b0;
        o_stb = 1'b0;
        o_we = 1'b0;
        o_adr = 8'h00;
        o_sel = 4'h0;
        o_dat = 32'h0;
    end
    // One byte register per word
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge i_clk);
        o_cyc <= 1'b1;
        o_stb <= 1'b1;
        o_we <= w;
        o_adr <= a;
        o_sel <= 4'h1;
        o_dat <= {24'h0, d};
        do @(posedge i_clk);
        while (i_ack !== 1'b1);
        q = i_dat[7:0];
        o_cyc <= 1'b0;
        o_stb <= 1'b0;
        o_we <= 1'b0;
        o_dat <= ~o_dat;
    endtask
endmodule // assc_host

//--- verification/testbench.sv
// Purpose: Self-checking bench for the seek, sense and set-features block
// Assumes: Short seek and sense counts
// Notes: Set-features cases run from a table
`timescale 1ns/1ps
module testbench;
    import assc_pkg::*;
    typedef struct packed {
        logic [7:0] fc;
        logic [7:0] sc;
        logic [7:0] ft;
        logic [7:0] xm;
        logic ab;
    } assc_row_t;
    localparam int NR = 28;
    localparam assc_row_t ROWS [NR] = '{
        '{8'h82, 8'h00, 8'h40, 8'h00, 1'b0}, '{8'h02, 8'h00, 8'hc0, 8'h00, 1'b0},
        '{8'h55, 8'h00, 8'h80, 8'h00, 1'b0}, '{8'haa, 8'h00, 8'hc0, 8'h00, 1'b0},
        '{8'hcc, 8'h00, 8'hd0, 8'h00, 1'b0}, '{8'h66, 8'h00, 8'hc0, 8'h00, 1'b0},
        '{8'h09, 8'h00, 8'hc8, 8'h00, 1'b0}, '{8'h89, 8'h00, 8'hc0, 8'h00, 1'b0},
        '{8'h44, 8'h00, 8'he0, 8'h00, 1'b0}, '{8'hbb, 8'h00, 8'hc0, 8'h00, 1'b0},
        '{8'h05, 8'hc0, 8'hc4, 8'h00, 1'b0}, '{8'h05, 8'hfe, 8'hc4, 8'h00, 1'b0},
        '{8'h05, 8'hbf, 8'hc5, 8'h00, 1'b0}, '{8'h05, 8'h80, 8'hc5, 8'h00, 1'b0},
        '{8'h05, 8'h7f, 8'hc6, 8'h00, 1'b0}, '{8'h05, 8'h01, 8'hc6, 8'h00, 1'b0},
        '{8'h05, 8'h00, 8'hc6, 8'h00, 1'b1}, '{8'h05, 8'hff, 8'hc6, 8'h00, 1'b1},
        '{8'h85, 8'h00, 8'hc0, 8'h00, 1'b0}, '{8'h03, 8'h01, 8'hc0, 8'h01, 1'b0},
        '{8'h03, 8'h0c, 8'hc0, 8'h0c, 1'b0}, '{8'h03, 8'h22, 8'hc0, 8'h22, 1'b0},
        '{8'h03, 8'h44, 8'hc0, 8'h44, 1'b0}, '{8'h03, 8'h0d, 8'hc0, 8'h44, 1'b1},
        '{8'h03, 8'h23, 8'hc0, 8'h44, 1'b1}, '{8'h03, 8'h00, 8'hc0, 8'h00, 1'b0},
        '{8'h77, 8'h00, 8'hc0, 8'h00, 1'b1}, '{8'h00, 8'h00, 8'hc0, 8'h00, 1'b1}};
    logic clk = 1'b0;
    logic rst_n, cyc, stb, we, ack, over, spare, hrst, seek_req, seek_lba, spin;
    logic [7:0] adr, temp, xmode, q, first_st, last_st;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [27:0] seek_tgt, cap_tgt;
    logic cap_lba;
    assc_feat_t feat;
    int num_errors, num_checks, seek_cnt;
    assc_host host (.i_clk(clk), .o_cyc(cyc), .o_stb(stb), .o_we(we), .o_adr(adr),
        .o_sel(sel), .o_dat(wdat), .i_dat(rdat), .i_ack(ack));
    assc_cmd #(.SEEK_CYCLES(4), .SENSE_CYCLES(2)) dut (.I_MCLK(clk), .I_RST_N(rst_n),
        .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
        .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_TEMP_CODE(temp),
        .I_OVERSTRESS(over), .I_SPARE_EXHAUSTED(spare), .I_HARD_RESET(hrst),
        .O_SEEK_REQ(seek_req), .O_SEEK_TARGET(seek_tgt), .O_SEEK_LBA(seek_lba),
        .O_SPINDLE_SPINUP(spin), .O_FEATURES(feat), .O_XFER_MODE(xmode));
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (seek_req === 1'b1) begin
            seek_cnt <= seek_cnt + 1;
            cap_tgt <= seek_tgt;
            cap_lba <= seek_lba;
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] t;
        host.xfer(1'b1, a, d, t);
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
        host.xfer(1'b0, a, 8'h00, q);
        chk(n, q, e);
    endtask
    task automatic run(input logic [7:0] op);
        wr(ADR_COMMAND, op);
        host.xfer(1'b0, ADR_STATUS, 8'h00, first_st);
        last_st = first_st;
        for (int k = 0; k < 40 && last_st[ST_BSY_BIT] !== 1'b0; k++) begin
            host.xfer(1'b0, ADR_STATUS, 8'h00, last_st);
        end
        chk("done", last_st[ST_BSY_BIT], 1'b0);
    endtask
    task automatic sf(input logic [7:0] fc, input logic [7:0] sc);
        wr(ADR_FEATURE, fc);
        wr(ADR_SECCNT, sc);
        run(OP_SETFEAT);
    endtask
    // No write command precedes these pulses
    task automatic hr();
        hrst <= 1'b1;
        repeat (4) @(posedge clk);
        hrst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic close_out();
        if (num_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        close_out();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        temp = 8'h00;
        over = 1'b0;
        spare = 1'b0;
        hrst = 1'b0;
        repeat (8) @(posedge clk);
        chk("ack_rst", ack, 1'b0);
        chk("feat_rst", feat, 8'hc0);
        rst_n <= 1'b1;
        rc("status_rst", ADR_STATUS, 8'h50);
        rc("error_rst", ADR_ERROR, 8'h00);
        rc("feat_reg_rst", ADR_FEAT_STATE, 8'hc0);
        for (int i = 0; i < NR; i++) begin
            sf(ROWS[i].fc, ROWS[i].sc);
            rc("error", ADR_ERROR, {5'h0, ROWS[i].ab, 2'h0});
            chk("status", last_st & 8'hc1, {7'h20, ROWS[i].ab});
            rc("feat_reg", ADR_FEAT_STATE, ROWS[i].ft);
            chk("feat_pin", feat, ROWS[i].ft);
            chk("xfer", xmode, ROWS[i].xm);
        end
        // Seek in logical then cylinder/head addressing
        wr(ADR_LBA_LOW, 8'h12);
        wr(ADR_LBA_MID, 8'h34);
        wr(ADR_LBA_HIGH, 8'h56);
        wr(ADR_DEVICE, 8'h47);
        run(8'h7f);
        chk("busy", first_st[ST_BSY_BIT], 1'b1);
        chk("seek_cnt", seek_cnt, 1);
        chk("lba_tgt", {cap_lba, cap_tgt}, 29'h17563412);
        rc("low_back", ADR_LBA_LOW, 8'h12);
        rc("mid_back", ADR_LBA_MID, 8'h34);
        rc("high_back", ADR_LBA_HIGH, 8'h56);
        host.xfer(1'b0, ADR_DEVICE, 8'h00, q);
        chk("head_back", q[3:0], 4'h7);
        wr(ADR_DEVICE, 8'h03);
        run(8'h70);
        chk("seek_cnt2", seek_cnt, 2);
        chk("chs_tgt", {cap_lba, cap_tgt}, 29'h03563400);
        // Temperature sense, then a bad feature value
        for (int i = 0; i < 3; i++) begin
            temp <= (i == 0) ? 8'h9a : ((i == 1) ? 8'hff : 8'h00);
            over <= (i == 0);
            repeat (4) @(posedge clk);
            wr(ADR_FEATURE, SENSE_FEAT);
            run(OP_SENSE);
            rc("temp", ADR_SECCNT, (i == 0) ? 8'h9a : ((i == 1) ? 8'hff : 8'h00));
            rc("overstress", ADR_LBA_LOW, {7'h0, i == 0});
            rc("sense_err", ADR_ERROR, 8'h00);
            chk("spinup", spin, 1'b0);
        end
        wr(ADR_FEATURE, 8'h02);
        run(OP_SENSE);
        rc("sense_abort", ADR_ERROR, 8'h04);
        // Hard reset with reverting off, then on
        sf(FC_RLA_OFF, 8'h00);
        hr();
        rc("keep", ADR_FEAT_STATE, 8'h80);
        sf(FC_REV_ON, 8'h00);
        hr();
        rc("revert", ADR_FEAT_STATE, 8'hc0);
        // Spare capacity exhausted
        spare <= 1'b1;
        repeat (4) @(posedge clk);
        chk("wc_forced", feat, 8'h40);
        sf(FC_WC_ON, 8'h00);
        rc("wc_err", ADR_ERROR, 8'h00);
        chk("wc_off", feat, 8'h40);
        close_out();
    end
endmodule // testbench
